// ===== hdl/cmx_core.sv
// Execution core for moves to direct memory, code table lookups,
// external data moves, unsigned multiply, OR to accumulator and no-op.
// Assumes a code memory and an external data memory that answer in the
// same clock in which the address or read strobe is presented.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Move carry into addressed bit; two bytes, two machine cycles.
// - Copy location at R0/R1 pointer to direct address; two bytes, two cycles.
// - Copy accumulator to direct address; two bytes, one cycle.
// - Copy any working register to direct address; two bytes, two cycles.
// - Lookup code byte at accumulator plus data pointer, counter restored.
// - Lookup code byte at incremented counter plus accumulator, counter restored.
// - Write accumulator to external memory at data pointer; two cycles.
// - Write accumulator to external memory at R0/R1 address; two cycles.
// - Read external memory at data pointer into accumulator; two cycles.
// - Read external memory at R0/R1 address into accumulator.
// - Multiply accumulator by B unsigned; low to accumulator, high to B.
// - Multiply clears carry; overflow set when product exceeds 00FFH.
// - No-operation only advances the program counter by one.
// - OR immediate byte into accumulator; two bytes, one cycle.
// - OR location at R0/R1 pointer into accumulator; one byte, one cycle.
module cmx_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Code memory
  output logic [15:0] codeAddr,
  input wire logic [7:0] codeData,
  // External data memory
  output cmx_pkg::cmx_xmem_type xmemReq,
  input wire logic [7:0] xmemRdData,
  // Status
  output logic [7:0] accOut,
  output logic [7:0] pswOut,
  output logic [15:0] pcOut,
  output logic instrDone,
  output logic badOpcode
);
  cmx_pkg::cmx_state_type state_reg;
  logic [cmx_pkg::CNT_W-1:0] cnt_reg;
  logic [15:0] pc_reg;
  logic [15:0] savedPc_reg;
  logic [15:0] codeAddr_reg;
  logic [7:0] opcode_reg;
  logic [7:0] operand_reg;
  logic [7:0] acc_reg, acc_next;
  logic [7:0] b_reg, b_next;
  logic [7:0] psw_reg, psw_next;
  logic [7:0] dpl_reg, dpl_next;
  logic [7:0] dph_reg, dph_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:0] iram [0:255];
  logic ramWe;
  logic [7:0] ramAddr;
  logic [7:0] ramData;
  logic done_reg;
  logic bad_reg;
  cmx_pkg::cmx_xmem_type xmem_reg;
  cmx_pkg::cmx_dec_type dec;
  cmx_pkg::cmx_dec_type fetchDec;
  logic [cmx_pkg::CNT_W-1:0] lastCnt;
  logic actNow;
  logic [7:0] operandVal;
  logic [7:0] ptrVal;
  logic [7:0] indVal;
  logic [7:0] regVal;
  logic [15:0] lookupAddr;
  logic [7:0] prodLo, prodHi;
  logic prodOv;
  logic parityNext;

  // Instruction decode, used for the opcode in flight and the one being fetched
  function automatic cmx_pkg::cmx_dec_type decode(input logic [7:0] op);
    cmx_pkg::cmx_dec_type d;
    d = '{twoByte: 1'b0, machineCycles: cmx_pkg::MC_ONE, kind: cmx_pkg::K_UNKNOWN};
    if (op == cmx_pkg::OP_NOP) begin
      d.kind = cmx_pkg::K_NOP;
    end else if (op == cmx_pkg::OP_MOV_BIT_C) begin
      d = '{1'b1, cmx_pkg::MC_TWO, cmx_pkg::K_MOV_BIT_C};
    end else if ((op & cmx_pkg::MASK_PTR_SEL) == cmx_pkg::OP_MOV_DIR_IND) begin
      d = '{1'b1, cmx_pkg::MC_TWO, cmx_pkg::K_MOV_DIR_IND};
    end else if (op == cmx_pkg::OP_MOV_DIR_A) begin
      d = '{1'b1, cmx_pkg::MC_ONE, cmx_pkg::K_MOV_DIR_A};
    end else if ((op & cmx_pkg::MASK_REG_SEL) == cmx_pkg::OP_MOV_DIR_REG) begin
      d = '{1'b1, cmx_pkg::MC_TWO, cmx_pkg::K_MOV_DIR_REG};
    end else if (op == cmx_pkg::OP_LOOKUP_DP) begin
      d = '{1'b0, cmx_pkg::MC_TWO, cmx_pkg::K_LOOKUP_DP};
    end else if (op == cmx_pkg::OP_LOOKUP_PC) begin
      d = '{1'b0, cmx_pkg::MC_TWO, cmx_pkg::K_LOOKUP_PC};
    end else if (op == cmx_pkg::OP_XWR_DP) begin
      d = '{1'b0, cmx_pkg::MC_TWO, cmx_pkg::K_XWR_DP};
    end else if ((op & cmx_pkg::MASK_PTR_SEL) == cmx_pkg::OP_XWR_REG) begin
      d = '{1'b0, cmx_pkg::MC_TWO, cmx_pkg::K_XWR_REG};
    end else if (op == cmx_pkg::OP_XRD_DP) begin
      d = '{1'b0, cmx_pkg::MC_TWO, cmx_pkg::K_XRD_DP};
    end else if ((op & cmx_pkg::MASK_PTR_SEL) == cmx_pkg::OP_XRD_REG) begin
      d = '{1'b0, cmx_pkg::MC_TWO, cmx_pkg::K_XRD_REG};
    end else if (op == cmx_pkg::OP_MUL) begin
      d = '{1'b0, cmx_pkg::MC_FOUR, cmx_pkg::K_MUL};
    end else if (op == cmx_pkg::OP_OR_IMM) begin
      d = '{1'b1, cmx_pkg::MC_ONE, cmx_pkg::K_OR_IMM};
    end else if ((op & cmx_pkg::MASK_PTR_SEL) == cmx_pkg::OP_OR_IND) begin
      d = '{1'b0, cmx_pkg::MC_ONE, cmx_pkg::K_OR_IND};
    end
    return d;
  endfunction

  // Byte that holds a bit address: low half maps into the bit area of RAM
  function automatic logic [7:0] bitByte(input logic [7:0] bitAddr);
    if (bitAddr[7]) begin
      return {bitAddr[7:3], 3'b000};
    end
    return cmx_pkg::BIT_BYTE_BASE + {4'h0, bitAddr[6:3]};
  endfunction

  // Direct read: RAM below the special register area, unmapped reads zero
  function automatic logic [7:0] readDirect(input logic [7:0] addr);
    if (!addr[7]) begin
      return iram[addr];
    end
    unique case (addr)
      cmx_pkg::SFR_ACC: return acc_reg;
      cmx_pkg::SFR_B: return b_reg;
      cmx_pkg::SFR_PSW: return psw_reg;
      cmx_pkg::SFR_DPL: return dpl_reg;
      cmx_pkg::SFR_DPH: return dph_reg;
      cmx_pkg::SFR_SP: return sp_reg;
      default: return cmx_pkg::BYTE_RESET;
    endcase
  endfunction

  // Operand fetch and register lookups in the selected bank
  assign dec = decode(opcode_reg);
  // Byte count of the opcode on the bus decides whether an operand follows
  assign fetchDec = decode(codeData);
  assign lastCnt = cmx_pkg::CNT_W'(dec.machineCycles * cmx_pkg::MC_CLKS) - cmx_pkg::CNT_FIRST;
  assign actNow = ((state_reg == cmx_pkg::ST_OPND) || (state_reg == cmx_pkg::ST_EXEC))
                  && (cnt_reg == lastCnt);
  // The second byte is used straight off the bus when a two-byte op ends there
  assign operandVal = (state_reg == cmx_pkg::ST_OPND) ? codeData : operand_reg;
  assign ptrVal = iram[{3'b000, psw_reg[cmx_pkg::PSW_RS_HI:cmx_pkg::PSW_RS_LO], 2'b00,
                        opcode_reg[0]}];
  assign indVal = iram[ptrVal];
  assign regVal = iram[{3'b000, psw_reg[cmx_pkg::PSW_RS_HI:cmx_pkg::PSW_RS_LO],
                        opcode_reg[2:0]}];
  // Lookup sums; the counter has already been stepped past the opcode
  assign lookupAddr = (dec.kind == cmx_pkg::K_LOOKUP_DP) ?
                      {dph_reg, dpl_reg} + {8'h00, acc_reg} :
                      pc_reg + {8'h00, acc_reg};

  cmx_multiplier uMul (
    .factorA(acc_reg),
    .factorB(b_reg),
    .productLo(prodLo),
    .productHi(prodHi),
    .overflow(prodOv)
  );

  cmx_parity uPar (
    .dataIn(acc_next),
    .oddOnes(parityNext)
  );

  // Execute: next values of every special register
  always_comb begin
    logic dirWe;
    logic [7:0] dirAddr;
    logic [7:0] dirData;
    logic [7:0] oldByte;
    dirWe = 1'b0;
    dirAddr = operandVal;
    dirData = cmx_pkg::BYTE_RESET;
    oldByte = readDirect(bitByte(operandVal));
    acc_next = acc_reg;
    b_next = b_reg;
    psw_next = psw_reg;
    dpl_next = dpl_reg;
    dph_next = dph_reg;
    sp_next = sp_reg;
    ramWe = 1'b0;
    ramAddr = operandVal;
    ramData = cmx_pkg::BYTE_RESET;
    if (actNow) begin
      unique case (dec.kind)
        cmx_pkg::K_MOV_BIT_C: begin
          dirWe = 1'b1;
          dirAddr = bitByte(operandVal);
          dirData = oldByte;
          dirData[operandVal[2:0]] = psw_reg[cmx_pkg::PSW_CY];
        end
        cmx_pkg::K_MOV_DIR_IND: begin
          dirWe = 1'b1;
          dirData = indVal;
        end
        cmx_pkg::K_MOV_DIR_A: begin
          dirWe = 1'b1;
          dirData = acc_reg;
        end
        cmx_pkg::K_MOV_DIR_REG: begin
          dirWe = 1'b1;
          dirData = regVal;
        end
        cmx_pkg::K_MUL: begin
          acc_next = prodLo;
          b_next = prodHi;
          psw_next[cmx_pkg::PSW_CY] = 1'b0;
          psw_next[cmx_pkg::PSW_OV] = prodOv;
        end
        cmx_pkg::K_OR_IMM: acc_next = acc_reg | operandVal;
        cmx_pkg::K_OR_IND: acc_next = acc_reg | indVal;
        default: ;
      endcase
    end
    // Code byte lands in the accumulator while the counter holds the sum
    if (state_reg == cmx_pkg::ST_LOOK) begin
      acc_next = codeData;
    end
    // External read data is taken in the clock of the read strobe
    if ((state_reg == cmx_pkg::ST_EXEC) && (cnt_reg == cmx_pkg::CNT_XM_CAPTURE) &&
        ((dec.kind == cmx_pkg::K_XRD_DP) || (dec.kind == cmx_pkg::K_XRD_REG))) begin
      acc_next = xmemRdData;
    end
    // Direct writes land in a mapped special register or in RAM; others are dropped
    if (dirWe) begin
      unique case (dirAddr)
        cmx_pkg::SFR_ACC: acc_next = dirData;
        cmx_pkg::SFR_B: b_next = dirData;
        cmx_pkg::SFR_PSW: psw_next = dirData;
        cmx_pkg::SFR_DPL: dpl_next = dirData;
        cmx_pkg::SFR_DPH: dph_next = dirData;
        cmx_pkg::SFR_SP: sp_next = dirData;
        default: begin
          ramWe = !dirAddr[7];
          ramAddr = dirAddr;
          ramData = dirData;
        end
      endcase
    end
    // Parity always follows the accumulator, so a written flag is overridden
    psw_next[cmx_pkg::PSW_P] = parityNext;
  end

  // Architectural special registers
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc_reg <= cmx_pkg::BYTE_RESET;
      b_reg <= cmx_pkg::BYTE_RESET;
      psw_reg <= cmx_pkg::BYTE_RESET;
      dpl_reg <= cmx_pkg::BYTE_RESET;
      dph_reg <= cmx_pkg::BYTE_RESET;
      sp_reg <= cmx_pkg::SP_RESET;
    end else begin
      acc_reg <= acc_next;
      b_reg <= b_next;
      psw_reg <= psw_next;
      dpl_reg <= dpl_next;
      dph_reg <= dph_next;
      sp_reg <= sp_next;
    end
  end

  // Internal RAM; contents are not cleared by reset
  always_ff @(posedge clk_sys) begin
    if (ramWe) begin
      iram[ramAddr] <= ramData;
    end
  end

  // Sequencer: fetch, optional operand, execute, optional code lookup
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= cmx_pkg::ST_FETCH;
      cnt_reg <= '0;
      pc_reg <= cmx_pkg::WORD_RESET;
      savedPc_reg <= cmx_pkg::WORD_RESET;
      codeAddr_reg <= cmx_pkg::WORD_RESET;
      opcode_reg <= cmx_pkg::OP_NOP;
      operand_reg <= cmx_pkg::BYTE_RESET;
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      bad_reg <= 1'b0;
      cnt_reg <= cnt_reg + cmx_pkg::CNT_FIRST;
      unique case (state_reg)
        cmx_pkg::ST_FETCH: begin
          opcode_reg <= codeData;
          pc_reg <= pc_reg + 16'h0001;
          codeAddr_reg <= pc_reg + 16'h0001;
          cnt_reg <= cmx_pkg::CNT_FIRST;
          state_reg <= fetchDec.twoByte ? cmx_pkg::ST_OPND : cmx_pkg::ST_EXEC;
        end
        cmx_pkg::ST_OPND: begin
          operand_reg <= codeData;
          pc_reg <= pc_reg + 16'h0001;
          codeAddr_reg <= pc_reg + 16'h0001;
          state_reg <= actNow ? cmx_pkg::ST_FETCH : cmx_pkg::ST_EXEC;
        end
        cmx_pkg::ST_EXEC: begin
          if (((dec.kind == cmx_pkg::K_LOOKUP_DP) || (dec.kind == cmx_pkg::K_LOOKUP_PC))
              && (cnt_reg == cmx_pkg::CNT_FIRST)) begin
            // Sum is parked in the counter, the old value kept aside
            savedPc_reg <= pc_reg;
            pc_reg <= lookupAddr;
            codeAddr_reg <= lookupAddr;
            state_reg <= cmx_pkg::ST_LOOK;
          end else if (actNow) begin
            codeAddr_reg <= pc_reg;
            state_reg <= cmx_pkg::ST_FETCH;
          end
        end
        cmx_pkg::ST_LOOK: begin
          pc_reg <= savedPc_reg;
          state_reg <= cmx_pkg::ST_EXEC;
        end
      endcase
      // End-of-instruction marks; unknown opcodes run as one-cycle no-ops
      if (actNow) begin
        done_reg <= 1'b1;
        bad_reg <= (dec.kind == cmx_pkg::K_UNKNOWN);
        cnt_reg <= '0;
      end
    end
  end

  // External data memory strobes, one clock wide, registered in the first execute clock and seen on the bus in the second
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      xmem_reg <= '0;
    end else begin
      xmem_reg.wr <= 1'b0;
      xmem_reg.rd <= 1'b0;
      if ((state_reg == cmx_pkg::ST_EXEC) && (cnt_reg == cmx_pkg::CNT_FIRST)) begin
        unique case (dec.kind)
          cmx_pkg::K_XWR_DP, cmx_pkg::K_XRD_DP: begin
            xmem_reg.addr <= {dph_reg, dpl_reg};
            xmem_reg.wrData <= acc_reg;
            xmem_reg.wr <= (dec.kind == cmx_pkg::K_XWR_DP);
            xmem_reg.rd <= (dec.kind == cmx_pkg::K_XRD_DP);
          end
          cmx_pkg::K_XWR_REG, cmx_pkg::K_XRD_REG: begin
            // Pointer register gives only the low byte; the page is fixed
            xmem_reg.addr <= {cmx_pkg::XMEM_PAGE, ptrVal};
            xmem_reg.wrData <= acc_reg;
            xmem_reg.wr <= (dec.kind == cmx_pkg::K_XWR_REG);
            xmem_reg.rd <= (dec.kind == cmx_pkg::K_XRD_REG);
          end
          default: ;
        endcase
      end
    end
  end

  // Outputs
  assign codeAddr = codeAddr_reg;
  assign xmemReq = xmem_reg;
  assign accOut = acc_reg;
  assign pswOut = psw_reg;
  assign pcOut = pc_reg;
  assign instrDone = done_reg;
  assign badOpcode = bad_reg;
endmodule
`default_nettype wire

// ===== hdl/cmx_multiplier.sv
// Unsigned 8x8 multiplier with overflow indication.
// Purely combinational; the core registers its results.
`timescale 1ns/10ps
`default_nettype none
module cmx_multiplier (
  // Operands
  input wire logic [7:0] factorA,
  input wire logic [7:0] factorB,
  // Result
  output logic [7:0] productLo,
  output logic [7:0] productHi,
  output logic overflow
);
  logic [15:0] product;

  // Both operands are treated as unsigned bytes
  assign product = {8'h00, factorA} * {8'h00, factorB};
  assign productLo = product[7:0];
  assign productHi = product[15:8];
  // Above the limit exactly when the high byte is non-zero
  assign overflow = (product > {8'h00, cmx_pkg::PRODUCT_LIMIT});
endmodule
`default_nettype wire

// ===== hdl/cmx_parity.sv
// Odd-ones detector for the accumulator parity flag.
// Combinational; fed with the accumulator's next value.
`timescale 1ns/10ps
`default_nettype none
module cmx_parity (
  // Byte in
  input wire logic [7:0] dataIn,
  // Flag out
  output logic oddOnes
);
  // High for an odd count of one bits
  assign oddOnes = ^dataIn;
endmodule
`default_nettype wire

// ===== hdl/cmx_pkg.sv
// Constants and types for the move, multiply, OR and no-operation
// execution slice. Shared by the core and its multiplier helper module.
`default_nettype none
package cmx_pkg;

  // Opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_MOV_BIT_C = 8'h92;
  localparam logic [7:0] OP_MOV_DIR_IND = 8'h86;
  localparam logic [7:0] OP_MOV_DIR_A = 8'hF5;
  localparam logic [7:0] OP_MOV_DIR_REG = 8'h88;
  localparam logic [7:0] OP_LOOKUP_DP = 8'h93;
  localparam logic [7:0] OP_LOOKUP_PC = 8'h83;
  localparam logic [7:0] OP_XWR_DP = 8'hF0;
  localparam logic [7:0] OP_XWR_REG = 8'hF2;
  localparam logic [7:0] OP_XRD_DP = 8'hE0;
  localparam logic [7:0] OP_XRD_REG = 8'hE2;
  localparam logic [7:0] OP_MUL = 8'hA4;
  localparam logic [7:0] OP_OR_IMM = 8'h44;
  localparam logic [7:0] OP_OR_IND = 8'h46;
  // Masks that drop the register select from the opcode
  localparam logic [7:0] MASK_PTR_SEL = 8'hFE;
  localparam logic [7:0] MASK_REG_SEL = 8'hF8;

  // Direct addresses of the special registers
  localparam logic [7:0] SFR_ACC = 8'hE0;
  localparam logic [7:0] SFR_B = 8'hF0;
  localparam logic [7:0] SFR_PSW = 8'hD0;
  localparam logic [7:0] SFR_DPL = 8'h82;
  localparam logic [7:0] SFR_DPH = 8'h83;
  localparam logic [7:0] SFR_SP = 8'h81;
  localparam logic [7:0] BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] PRODUCT_LIMIT = 8'hFF;

  // Status word bit positions
  localparam int PSW_CY = 7;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_P = 0;

  // Reset values
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [7:0] XMEM_PAGE = 8'h00;

  // Timing: clocks per machine cycle and the counter slots used
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] MC_CLKS = 4'h2;
  localparam logic [2:0] MC_ONE = 3'h1;
  localparam logic [2:0] MC_TWO = 3'h2;
  localparam logic [2:0] MC_FOUR = 3'h4;
  localparam logic [CNT_W-1:0] CNT_FIRST = 4'h1;
  localparam logic [CNT_W-1:0] CNT_XM_CAPTURE = 4'h2;

  typedef enum logic [3:0] {
    K_NOP, K_MOV_BIT_C, K_MOV_DIR_IND, K_MOV_DIR_A, K_MOV_DIR_REG,
    K_LOOKUP_DP, K_LOOKUP_PC, K_XWR_DP, K_XWR_REG, K_XRD_DP, K_XRD_REG,
    K_MUL, K_OR_IMM, K_OR_IND, K_UNKNOWN
  } cmx_kind_type;

  typedef struct packed {
    logic twoByte;
    logic [2:0] machineCycles;
    cmx_kind_type kind;
  } cmx_dec_type;

  // Gray coded along fetch, operand, execute, lookup
  typedef enum logic [1:0] {
    ST_FETCH = 2'b00, ST_OPND = 2'b01, ST_EXEC = 2'b11, ST_LOOK = 2'b10
  } cmx_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wrData;
    logic wr;
    logic rd;
  } cmx_xmem_type;

endpackage
`default_nettype wire

// ===== verification/cmx_core_bench.sv
// Bench for the execution core: a random program against a reference model.
// Assumes the memory model answers at once and the checker is bound in.
`timescale 1ns/10ps
`default_nettype none
module cmx_core_bench;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] codeAddr, pcOut;
  logic [7:0] codeData, xmemRdData, accOut, pswOut;
  logic instrDone, badOpcode;
  cmx_pkg::cmx_xmem_type xmemReq;
  int error_cnt = 0;
  int n_checks = 0;
  // Reference state: accumulator, B, status, data pointer, counter
  int ma, mb, mp, dpl, dph, pc, cyc, xw, bad, cnt, done;
  int ram [256];
  logic [7:0] xm [65536];
  logic [7:0] sfr [5] = '{8'hE0, 8'hF0, 8'hD0, 8'h82, 8'h83};
  logic [7:0] ops [26] = '{8'h00, 8'h92, 8'h86, 8'h87, 8'hF5, 8'h88, 8'h89, 8'h8A, 8'h8B,
    8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h93, 8'h83, 8'hF0, 8'hF2, 8'hF3, 8'hE0, 8'hE2, 8'hE3,
    8'hA4, 8'h44, 8'h46, 8'h47, 8'hA5};

  // 50 ns period
  always #25 clk_sys = ~clk_sys;

  cmx_core u_cmx_core (.clk_sys(clk_sys), .sys_rst(sys_rst), .codeAddr(codeAddr),
    .codeData(codeData), .xmemReq(xmemReq), .xmemRdData(xmemRdData), .accOut(accOut),
    .pswOut(pswOut), .pcOut(pcOut), .instrDone(instrDone), .badOpcode(badOpcode));
  cmx_mem_model u_mem (.clk_sys(clk_sys), .codeAddr(codeAddr), .codeData(codeData),
    .xmemReq(xmemReq), .xmemRdData(xmemRdData));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic put(input int b);
    u_mem.code[pc] = 8'(b);
    pc++;
  endtask

  // Direct space of the model; unmapped special places read 0
  function automatic int rdd(input int ad);
    if (ad < 128) return ram[ad];
    if (ad == 8'hE0) return ma;
    if (ad == 8'hF0) return mb;
    if (ad == 8'hD0) return mp;
    if (ad == 8'h82) return dpl;
    return (ad == 8'h83) ? dph : 0;
  endfunction

  task automatic wrd(input int ad, input int v);
    if (ad < 128) ram[ad] = v;
    if (ad == 8'hE0) ma = v;
    if (ad == 8'hF0) mb = v;
    if (ad == 8'hD0) mp = v;
    if (ad == 8'h82) dpl = v;
    if (ad == 8'h83) dph = v;
  endtask

  // One instruction of the reference model at pc
  task automatic step;
    int op, o2, pt, ad, v, p;
    op = u_mem.code[pc];
    o2 = u_mem.code[pc + 1];
    pt = ram[mp[4:3] * 8 + op % 2];
    pc++;
    xw = -1;
    bad = 0;
    case (op)
      8'h92: begin
        ad = (o2 < 128) ? 32 + o2 / 8 : o2 - o2 % 8;
        v = rdd(ad);
        v[o2 % 8] = mp[7];
        wrd(ad, v);
      end
      8'h86, 8'h87: wrd(o2, ram[pt]);
      8'hF5: wrd(o2, ma);
      8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F: wrd(o2, ram[mp[4:3] * 8 + op % 8]);
      8'h93: ma = u_mem.code[(dph * 256 + dpl + ma) % 65536];
      8'h83: ma = u_mem.code[pc + ma];
      8'hF0: xw = dph * 256 + dpl;
      8'hF2, 8'hF3: xw = pt;
      8'hE0: ma = xm[dph * 256 + dpl];
      8'hE2, 8'hE3: ma = xm[pt];
      8'hA4: begin
        p = ma * mb;
        ma = p % 256;
        mb = p / 256;
        mp[7] = 1'b0;
        mp[2] = (p > 255);
      end
      8'h44: ma = ma | o2;
      8'h46, 8'h47: ma = ma | ram[pt];
      8'h00: bad = 0;
      default: bad = 1;
    endcase
    if (xw >= 0) xm[xw] = 8'(ma);
    if (op inside {8'h92, 8'h44, 8'hF5, [8'h86:8'h8F]}) pc++;
    cyc = (bad || op inside {8'h00, 8'hF5, 8'h44, 8'h46, 8'h47}) ? 1 : (op == 8'hA4) ? 4 : 2;
  endtask

  initial begin
    logic [7:0] op;
    void'($urandom(11235));
    // Random code and external data; the model keeps its own data copy
    for (int i = 0; i < 65536; i++) begin
      u_mem.code[i] = 8'($urandom);
      xm[i] = 8'($urandom);
      u_mem.xram[i] = xm[i];
    end
    // Clear direct memory, then give each pointer register a low address
    pc = 0;
    for (int i = 0; i < 128; i++) begin
      put(8'hF5);
      put(i);
    end
    for (int i = 0; i < 8; i++) begin
      put(8'h44);
      put($urandom % 128);
      put(8'hF5);
      put(i / 2 * 8 + i % 2);
      put(8'hA4);
    end
    // Random body; direct targets avoid the pointer registers
    for (int i = 0; i < 300; i++) begin
      op = ops[$urandom % 26];
      put(op);
      if (op inside {8'h92, 8'h44}) put($urandom);
      else if (op inside {8'hF5, [8'h86:8'h8F]}) put($urandom % 2 ? 32 + $urandom % 96 : sfr[$urandom % 5]);
    end
    repeat (6) @(negedge clk_sys);
    sys_rst = 1'b0;
    pc = 0;
    step();
    // Every completion is checked against the model, bounded by a clock count
    while (done < 452) begin
      @(negedge clk_sys);
      cnt++;
      if (cnt > 16) begin
        check(16'(cnt), 16'(2 * cyc));
        wrap_up();
      end
      if (instrDone === 1'b1) begin
        check(16'(cnt), 16'(2 * cyc));
        check(16'(accOut), 16'(ma));
        check(16'(pswOut), 16'({mp[7:1], ^ma[7:0]}));
        check(pcOut, 16'(pc));
        check(16'(badOpcode), 16'(bad));
        if (xw >= 0) check(16'(u_mem.xram[xw]), 16'(xm[xw]));
        cnt = 0;
        done++;
        if (done == 152) $display("test setup sequence done");
        step();
      end
    end
    $display("test random sequence done");
    wrap_up();
  end
endmodule
`default_nettype wire

// ===== verification/cmx_core_props.sv
// Port-level assertions for the execution core.
// Assumes it is bound to cmx_core and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module cmx_core_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Memories
  input wire logic [15:0] codeAddr,
  input wire logic [7:0] codeData,
  input wire cmx_pkg::cmx_xmem_type xmemReq,
  input wire logic [7:0] xmemRdData,
  // Status
  input wire logic [7:0] accOut,
  input wire logic [7:0] pswOut,
  input wire logic [15:0] pcOut,
  input wire logic instrDone,
  input wire logic badOpcode
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  // Opcode taken in the clock that carries the previous completion
  sequence s_fetch(logic [7:0] op);
    instrDone && codeData == op;
  endsequence
  // Completion exactly four clocks after the fetch, none in between
  sequence s_wait4;
    !instrDone [*3] ##1 instrDone;
  endsequence

  AST_BIT_MOVE: assert property (s_fetch(8'h92) |=> s_wait4)
    else $error("Bit move did not take two machine cycles");
  AST_IND_DIR: assert property ((instrDone && codeData[7:1] == 7'h43) |=> s_wait4)
    else $error("Indirect to direct move did not take two machine cycles");
  AST_ACC_DIR: assert property (s_fetch(8'hF5) |=>
    !instrDone ##1 (instrDone && pcOut == $past(pcOut, 2) + 16'h0002))
    else $error("Accumulator to direct move wrong length or counter");
  AST_REG_DIR: assert property ((instrDone && codeData[7:3] == 5'h11) |=> s_wait4)
    else $error("Register to direct move did not take two machine cycles");
  AST_LOOKUP: assert property ((instrDone && (codeData == 8'h93 || codeData == 8'h83))
    |-> ##4 instrDone && pcOut == $past(pcOut, 4) + 16'h0001)
    else $error("Table lookup did not restore the counter");
  AST_XWRITE: assert property ((instrDone && (codeData == 8'hF0 || codeData[7:1] == 7'h79))
    |-> ##2 (xmemReq.wr && xmemReq.wrData == accOut) ##2 instrDone)
    else $error("External write strobe or data wrong");
  AST_XPAGE: assert property ((instrDone && codeData[7:1] == 7'h79)
    |-> ##2 xmemReq.wr && xmemReq.addr[15:8] == 8'h00)
    else $error("Pointer register write left the low page");
  AST_XREAD: assert property ((instrDone && (codeData == 8'hE0 || codeData[7:1] == 7'h71))
    |-> ##2 xmemReq.rd ##1 accOut == $past(xmemRdData) ##1 instrDone)
    else $error("External read data not loaded into accumulator");
  AST_MULTIPLY: assert property (s_fetch(8'hA4) |=>
    !instrDone [*7] ##1 (instrDone && !pswOut[7]))
    else $error("Multiply length or carry wrong");
  AST_NO_OP: assert property (s_fetch(8'h00) |=> !instrDone ##1 (instrDone &&
    pcOut == $past(pcOut, 2) + 16'h0001 && accOut == $past(accOut, 2)
    && pswOut == $past(pswOut, 2)))
    else $error("No-operation changed state beyond the counter");
  AST_OR_IMM: assert property (s_fetch(8'h44) |-> ##2 instrDone &&
    accOut == ($past(accOut, 2) | $past(codeData, 1)))
    else $error("Immediate OR result wrong");
  AST_OR_IND: assert property ((instrDone && codeData[7:1] == 7'h23) |-> ##2 instrDone
    && (accOut & $past(accOut, 2)) == $past(accOut, 2))
    else $error("Indirect OR cleared accumulator bits or took too long");
  AST_PARITY: assert property (instrDone |-> pswOut[0] == ^accOut)
    else $error("Parity flag does not match accumulator");
endmodule

bind cmx_core cmx_core_props u_cmx_core_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .codeAddr(codeAddr), .codeData(codeData), .xmemReq(xmemReq), .xmemRdData(xmemRdData),
  .accOut(accOut), .pswOut(pswOut), .pcOut(pcOut), .instrDone(instrDone),
  .badOpcode(badOpcode));
`default_nettype wire

// ===== verification/cmx_mem_model.sv
// Code memory and external data memory seen from the execution core.
// Assumes the core samples code and read data in the clock it asks.
`timescale 1ns/10ps
`default_nettype none
module cmx_mem_model (
  // Clock
  input wire logic clk_sys,
  // Code side
  input wire logic [15:0] codeAddr,
  output logic [7:0] codeData,
  // External data side
  input wire cmx_pkg::cmx_xmem_type xmemReq,
  output logic [7:0] xmemRdData
);
  logic [7:0] code [65536];
  logic [7:0] xram [65536];
  logic [7:0] lastRd = 8'h00;

  // Zero-wait answers; an idle data bus shows the inverse of the last byte read
  assign codeData = code[codeAddr];
  assign xmemRdData = xmemReq.rd ? xram[xmemReq.addr] : ~lastRd;

  // Store on the write strobe, remember the byte last read
  always @(posedge clk_sys) begin
    if (xmemReq.wr) xram[xmemReq.addr] <= xmemReq.wrData;
    if (xmemReq.rd) lastRd <= xram[xmemReq.addr];
  end
endmodule
`default_nettype wire
